//--- logic/warm_reset_cfg.svh
`ifndef WARM_RESET_CFG_SVH
`define WARM_RESET_CFG_SVH

// Core clock period in ns
`define MCLK_NS 100
// Restart timing figures in ns
`define RESTART_RECOVERY_TIME_NS 35000
`define RESTART_PULSE_WIDTH_NS 200
`define RESTART_REARM_TIME_NS 50
`define RESTART_RELEASE_HOLD_NS 50
// Least times round up to whole core cycles
`define RECOVERY_CYC ((`RESTART_RECOVERY_TIME_NS + `MCLK_NS - 1) / `MCLK_NS)
`define PULSE_CYC ((`RESTART_PULSE_WIDTH_NS + `MCLK_NS - 1) / `MCLK_NS)
`define REARM_CYC ((`RESTART_REARM_TIME_NS + `MCLK_NS - 1) / `MCLK_NS)
`define RELEASE_CYC ((`RESTART_RELEASE_HOLD_NS + `MCLK_NS - 1) / `MCLK_NS)
// Power-up length in core cycles, plain default
`define POWER_UP_CYC 3000
// Timer width and command byte width
`define TIMER_W 20
`define CMD_W 8

`endif

//--- logic/warm_reset_pkg.sv
`default_nettype none
package warm_reset_pkg;
  typedef enum logic [4:0] {
    ST_POR     = 5'b0_0001,
    ST_READY   = 5'b0_0010,
    ST_RECOVER = 5'b0_0100,
    ST_HOLD    = 5'b0_1000,
    ST_RELEASE = 5'b1_0000
  } seq_state_t;

  typedef struct packed {
    logic ready;
    logic out_float;
    logic por_good;
    logic in_por;
  } status_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } cmd_t;
endpackage
`default_nettype wire

//--- logic/link_shifter.sv
`timescale 1ns/1ps
`default_nettype none
`include "warm_reset_cfg.svh"
module link_shifter (
  input  wire logic              sclk,
  input  wire logic              reset_n,
  input  wire logic              cs_n,
  input  wire logic              hold,
  input  wire logic              si,
  output var  logic [`CMD_W-1:0] code,
  output var  logic              code_tgl
);
  logic [`CMD_W-2:0] shift;
  logic [2:0]        bit_cnt;
  logic              frame_clr;

  // Deselect or a pending restart drops the frame back to idle at once,
  // since the serial clock may be standing still
  assign frame_clr = cs_n | hold;

  always_ff @(posedge sclk or posedge frame_clr) begin
    if (frame_clr) begin
      bit_cnt <= 3'h0;
      shift   <= '0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shift   <= {shift[`CMD_W-3:0], si};
    end
  end

  // Kept out of the frame reset so the toggle never moves on its own
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      code     <= '0;
      code_tgl <= 1'b0;
    end else if (!frame_clr && bit_cnt == 3'h7) begin
      code     <= {shift, si};
      code_tgl <= ~code_tgl;
    end
  end
endmodule // link_shifter
`default_nettype wire

//--- logic/warm_reset_sequencer.sv
// Functional notes
// - Restart falling edge restores power-on register values
// - Abbreviated restart lasts at least 35 us
// - Unfinished power-on turns restart into full power-on
// - Low 200 ns: abort, float outputs, ignore commands; a restart that starts a full power-up neither aborts nor floats outputs unless still low when power-up ends
// - Restart returns serial interface to idle
// - Restart low ignored during power-up
// - Restart low at power-up end holds reset
`timescale 1ns/1ps
`default_nettype none
`include "warm_reset_cfg.svh"
module warm_reset_sequencer #(
  parameter int POWER_UP_CYC = `POWER_UP_CYC
) (
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  input  wire logic                     restart_n,
  input  wire logic                     por_fail,
  input  wire logic                     sclk,
  input  wire logic                     cs_n,
  input  wire logic                     si,
  output var  warm_reset_pkg::status_t  status,
  output var  warm_reset_pkg::cmd_t     cmd,
  output var  logic                     reg_clear,
  output var  logic                     abort_op,
  output var  logic                     iface_hold
);
  import warm_reset_pkg::*;

  localparam logic [`TIMER_W-1:0] T_RECOVER = `TIMER_W'(`RECOVERY_CYC);
  localparam logic [`TIMER_W-1:0] T_POWER   = `TIMER_W'(POWER_UP_CYC);
  localparam logic [`TIMER_W-1:0] T_RELEASE = `TIMER_W'(`RELEASE_CYC > `REARM_CYC ?
                                                        `RELEASE_CYC : `REARM_CYC);
  localparam logic [3:0]          T_PULSE   = 4'(`PULSE_CYC);

  seq_state_t          state;
  seq_state_t          next_state;
  logic [`TIMER_W-1:0] timer;
  logic [`TIMER_W-1:0] next_timer;
  logic [2:0]          rst_sync;
  logic                rst_lvl;
  logic                rst_fall;
  logic [3:0]          low_cnt;
  logic [2:0]          tgl_sync;
  logic                tgl_seen;
  logic                cmd_evt;
  logic [`CMD_W-1:0]   link_code;
  logic                link_tgl;

  // Pin input: three stages, a change counts once stages two and three agree
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 3'b111;
      rst_lvl  <= 1'b1;
    end else begin
      rst_sync <= {rst_sync[1:0], restart_n};
      if (rst_sync[1] == rst_sync[2]) begin
        rst_lvl <= rst_sync[2];
      end
    end
  end

  assign rst_fall = rst_lvl && (rst_sync[1] == rst_sync[2]) && !rst_sync[2];

  // Command toggle from the serial clock domain
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tgl_sync <= 3'b000;
      tgl_seen <= 1'b0;
    end else begin
      tgl_sync <= {tgl_sync[1:0], link_tgl};
      if (tgl_sync[1] == tgl_sync[2]) begin
        tgl_seen <= tgl_sync[2];
      end
    end
  end

  assign cmd_evt = (tgl_sync[1] == tgl_sync[2]) && (tgl_sync[2] != tgl_seen);

  // Timer runs on the core clock: the serial clock may idle throughout
  always_comb begin
    next_state = state;
    next_timer = (timer != '0) ? timer - `TIMER_W'(1) : timer;
    case (state)
      ST_POR: begin
        // Restart level is not looked at until power-up ends
        if (timer == '0) begin
          if (!rst_lvl) begin
            next_state = ST_HOLD;
          end else begin
            next_state = ST_READY;
          end
        end
      end
      ST_READY: begin
        if (rst_fall) begin
          if (status.por_good) begin
            next_state = ST_RECOVER;
            next_timer = T_RECOVER;
          end else begin
            next_state = ST_POR;
            next_timer = T_POWER;
          end
        end
      end
      ST_RECOVER: begin
        if (timer == '0) begin
          next_state = rst_lvl ? ST_RELEASE : ST_HOLD;
          next_timer = T_RELEASE;
        end
      end
      ST_HOLD: begin
        if (rst_lvl) begin
          next_state = ST_RELEASE;
          next_timer = T_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (!rst_lvl) begin
          next_state = ST_HOLD;
        end else if (timer == '0) begin
          next_state = ST_READY;
        end
      end
      default: begin
        next_state = ST_POR;
        next_timer = T_POWER;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_POR;
      timer <= `TIMER_W'(POWER_UP_CYC);
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // Low-pulse width while recovering; long enough means abort and float
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= 4'h0;
    end else if (state == ST_READY || state == ST_POR || rst_lvl) begin
      // Power-up disregards the pin, so no abort can come from it there
      low_cnt <= 4'h0;
    end else if (low_cnt != T_PULSE) begin
      low_cnt <= low_cnt + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      abort_op         <= 1'b0;
      status.out_float <= 1'b1;
    end else begin
      abort_op <= (low_cnt == T_PULSE - 4'h1) && !rst_lvl && (state != ST_READY);
      if (next_state == ST_READY) begin
        status.out_float <= 1'b0;
      end else if (low_cnt == T_PULSE - 4'h1 && !rst_lvl) begin
        status.out_float <= 1'b1;
      end
    end
  end

  // A failed power-up leaves por_good low so the next restart is a full one
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status.por_good <= 1'b0;
      status.in_por   <= 1'b1;
      status.ready    <= 1'b0;
      iface_hold      <= 1'b1;
      reg_clear       <= 1'b0;
    end else begin
      if (state == ST_POR && timer == '0) begin
        status.por_good <= !por_fail;
      end
      status.in_por <= (next_state == ST_POR);
      status.ready  <= (next_state == ST_READY);
      iface_hold    <= (next_state != ST_READY);
      reg_clear     <= (state == ST_READY) && rst_fall;
    end
  end

  // Commands reach the core only in standby
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd <= '0;
    end else begin
      cmd.valid <= cmd_evt && (state == ST_READY) && !iface_hold;
      if (cmd_evt) begin
        cmd.code <= link_code;
      end
    end
  end

  link_shifter u_link (
    .sclk     (sclk),
    .reset_n  (reset_n),
    .cs_n     (cs_n),
    .hold     (iface_hold),
    .si       (si),
    .code     (link_code),
    .code_tgl (link_tgl)
  );

  // Checking helpers
  localparam int RECOVER_CYC = `RECOVERY_CYC;
  logic [`TIMER_W-1:0] since_fall;
  logic                warm_path;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      since_fall <= '0;
      warm_path  <= 1'b0;
    end else if (state == ST_READY && rst_fall) begin
      since_fall <= '0;
      warm_path  <= status.por_good;
    end else if (since_fall != '1) begin
      since_fall <= since_fall + `TIMER_W'(1);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_fall_clears_regs: assert property (state == ST_READY && rst_fall |=> reg_clear)
    else $error("Restart fall did not clear registers");
  a_recovery_min: assert property ($rose(status.ready) && warm_path |->
                                   since_fall >= RECOVER_CYC)
    else $error("Ready returned before recovery time");
  a_por_fallback: assert property (state == ST_READY && rst_fall && !status.por_good |=>
                                   state == ST_POR ##1 status.in_por)
    else $error("Failed power-up did not restart full power-up");
  a_abort_float: assert property (state == ST_RECOVER && !rst_lvl [*3] |->
                                  status.out_float)
    else $error("Outputs not floated after long restart pulse");
  a_cmd_ignored: assert property (!status.ready |=> !cmd.valid)
    else $error("Command accepted outside standby");
  a_iface_idle: assert property (state == ST_RECOVER |-> iface_hold)
    else $error("Interface not held idle during recovery");
  a_por_ignores: assert property (state == ST_POR && timer != '0 |=>
                                  state == ST_POR)
    else $error("Restart acted on during power-up");
  a_hold_low: assert property (state == ST_HOLD && !rst_lvl |=> !status.ready)
    else $error("Left reset while restart still low");
  a_timer_runs: assert property (state == ST_RECOVER && timer != '0 |=>
                                 timer == $past(timer) - 1)
    else $error("Recovery timer stalled");

  c_warm_restart: cover property (state == ST_RECOVER ##1 state == ST_RELEASE);
  c_full_restart: cover property (state == ST_READY ##1 state == ST_POR);
  c_hold_release: cover property (state == ST_HOLD ##1 state == ST_RELEASE);
  c_command: cover property (cmd.valid);
endmodule // warm_reset_sequencer
`default_nettype wire

//--- test/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output var logic restart_n,
  output var logic cs_n,
  output var logic sclk,
  output var logic si
);
  initial begin
    restart_n = 1'b1;
    cs_n      = 1'b1;
    sclk      = 1'b0;
    si        = 1'b0;
  end

  // Link clock runs only inside a frame; si flips after the last clock, whether or not the frame is released
  task automatic send_bits(input logic [7:0] b, input int n, input logic keep);
    cs_n = 1'b0;
    #20;
    for (int i = 7; i > 7 - n; i--) begin
      si = b[i];
      // 32 ns period stays under every command class limit
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    #20;
    if (!keep) begin
      cs_n = 1'b1;
    end
    si = ~si;
    #60;
  endtask

  task automatic set_restart(input logic v);
    restart_n = v;
  endtask

  task automatic restart(input int low_ns);
    restart_n = 1'b0;
    #100 cs_n = 1'b1;
    #(low_ns - 100) restart_n = 1'b1;
    #100;
  endtask
endmodule // spi_host_model
`default_nettype wire

//--- test/spi_flash_warm_reset_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "warm_reset_cfg.svh"
module spi_flash_warm_reset_sequencer_tb_top;
  import warm_reset_pkg::*;
  localparam int PU_CYC = 20;
  logic    mclk;
  logic    reset_n;
  logic    por_fail;
  logic    restart_n;
  logic    cs_n;
  logic    sclk;
  logic    si;
  status_t status;
  cmd_t    cmd;
  logic    reg_clear;
  logic    abort_op;
  logic    iface_hold;
  int      n_mismatch;
  int      num_checks;
  int      n_clr;
  int      n_abort;
  int      n_cmd;
  int      cyc;
  int      n;

  warm_reset_sequencer #(.POWER_UP_CYC(PU_CYC)) DUT (
    .mclk(mclk), .reset_n(reset_n), .restart_n(restart_n), .por_fail(por_fail),
    .sclk(sclk), .cs_n(cs_n), .si(si), .status(status), .cmd(cmd),
    .reg_clear(reg_clear), .abort_op(abort_op), .iface_hold(iface_hold)
  );
  spi_host_model host (.restart_n(restart_n), .cs_n(cs_n), .sclk(sclk), .si(si));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Pulses are counted mid-cycle, where they have settled
  always @(negedge mclk) begin
    cyc++;
    if (reg_clear === 1'b1) n_clr++;
    if (abort_op === 1'b1) n_abort++;
    if (cmd.valid === 1'b1) n_cmd++;
    if (cyc == 6000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic do_reset();
    @(negedge mclk) reset_n = 1'b0;
    repeat (16) @(negedge mclk);
    reset_n = 1'b1;
  endtask

  task automatic wait_ready(input int max, output int k);
    k = 0;
    while (status.ready !== 1'b1 && k < max) begin
      @(negedge mclk);
      k++;
    end
    #1;
  endtask

  task automatic t_power_up();
    // Let the model's own start-up values settle first
    @(negedge mclk);
    host.set_restart(1'b0);
    do_reset();
    repeat (40) @(posedge mclk);
    #1;
    check("ready_held", status.ready, 1'b0);
    host.set_restart(1'b1);
    wait_ready(10, n);
    check("ready_after_release", status.ready, 1'b1);
    check("por_good", status.por_good, 1'b1);
    check("out_float", status.out_float, 1'b0);
    check("iface_free", iface_hold, 1'b0);
    $display("test power_up done");
  endtask

  task automatic t_restart();
    int c0;
    int a0;
    int m0;
    int f0;
    c0 = n_clr;
    a0 = n_abort;
    host.send_bits(8'h5A, 8, 1'b0);
    repeat (6) @(posedge mclk);
    check("cmd_code", cmd.code, 8'h5A);
    check("cmd_count", n_cmd, 1);
    host.send_bits(8'hF0, 4, 1'b1);
    f0 = cyc;
    host.restart(400);
    // Detection takes up to four cycles, the abort two more
    repeat (4) @(negedge mclk);
    check("out_float", status.out_float, 1'b1);
    check("iface_hold", iface_hold, 1'b1);
    check("reg_clear_pulse", n_clr - c0, 1);
    check("abort_pulse", n_abort - a0, 1);
    m0 = n_cmd;
    host.send_bits(8'h11, 8, 1'b0);
    repeat (6) @(posedge mclk);
    check("cmd_ignored", n_cmd - m0, 0);
    wait_ready(500, n);
    check("ready_back", status.ready, 1'b1);
    check("recovery_long", (cyc - f0 >= `RECOVERY_CYC) && (cyc - f0 <= `RECOVERY_CYC + 12), 1'b1);
    host.send_bits(8'h3C, 8, 1'b0);
    repeat (6) @(posedge mclk);
    check("cmd_after", cmd.code, 8'h3C);
    check("cmd_after_count", n_cmd - m0, 1);
    $display("test restart done");
  endtask

  task automatic t_por_fail();
    int c0;
    int f0;
    @(negedge mclk) por_fail = 1'b1;
    do_reset();
    wait_ready(60, n);
    check("por_good_low", status.por_good, 1'b0);
    @(negedge mclk) por_fail = 1'b0;
    c0 = n_clr;
    f0 = cyc;
    host.restart(300);
    repeat (3) @(posedge mclk);
    #1;
    check("in_por", status.in_por, 1'b1);
    check("reg_clear_full", n_clr - c0, 1);
    wait_ready(300, n);
    check("full_por_done", status.ready, 1'b1);
    check("full_por_len", (cyc - f0 >= PU_CYC) && (cyc - f0 <= PU_CYC + 12), 1'b1);
    check("por_good", status.por_good, 1'b1);
    $display("test por_fail done");
  endtask

  initial begin
    reset_n = 1'b0;
    por_fail = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    n_clr = 0;
    n_abort = 0;
    n_cmd = 0;
    cyc = 0;
    t_power_up();
    t_restart();
    t_por_fail();
    print_verdict();
  end
endmodule // spi_flash_warm_reset_sequencer_tb_top
`default_nettype wire
